/* File: axis_pins_pkg.sv */
// constants shared by the per-axis pin logic of the four-axis controller
// assumes a single system clock domain and host strobes on that clock
`default_nettype none
package axis_pins_pkg;
   localparam int NUM_AXES       = 4;
   localparam int POS_W          = 32;
   localparam int HALF_PERIOD_W  = 16;
   localparam int HOST_DATA_W    = 16;
   localparam int GPO_PER_AXIS   = 4;
   // field of the axis output register that carries outputs 7..4
   localparam int AXIS_OUT_LSB   = 8;
   // position of the drive-status bits inside the upper output group
   localparam int STAT_DECEL_BIT = 3;
   localparam int STAT_ACCEL_BIT = 2;
   localparam int STAT_BELOW_LOWER_COMPARE_OUT_BIT  = 1;
   localparam int STAT_ABOVE_UPPER_COMPARE_OUT_BIT  = 0;
   localparam logic [GPO_PER_AXIS-1:0] GPO_RESET = 4'h0;
   localparam logic [POS_W-1:0] POS_RESET = 32'h00000000;
   localparam logic [POS_W-1:0] POS_ONE   = 32'h00000001;
   localparam logic [HALF_PERIOD_W-1:0] HP_RESET = 16'h0000;
   localparam logic [HALF_PERIOD_W-1:0] HP_ONE   = 16'h0001;
   // one-hot states of the drive pulse generator
   typedef enum logic [2:0] {
      PULSE_IDLE = 3'b001,
      PULSE_HIGH = 3'b010,
      PULSE_LOW  = 3'b100
   } pulse_e;
endpackage
`default_nettype wire

/* File: axis_pulse_and_status_outputs.sv */
// per-axis pulse generator, encoder counter, motion/clear pin and outputs
// assumes CLK_SYS is the already halved system clock; encoder and
// in-position pins are asynchronous, all other inputs are on CLK_SYS
// What this block does
// - minus pin pulses in two-pulse mode, shows direction in pulse-dir mode
// - drive pulses at constant speed have equal high and low time
// - quadrature mode decodes phases A and B into up/down counts
// - up/down mode: rising edge of phase A counts real position up
// - up/down mode: rising edge of phase B counts real position down
// - motion-active output is high while the axis emits drive pulses
// - motion-active output is high during automatic home search
// - motion-active output is high while an interpolation drive runs
// - with in-position enabled, motion-active stays high until it arrives
// - shared pin outputs deviation clear when home search mode selects it
// - after reset the shared pin shows motion-active
// - outputs 7..4 of selected axes take bits 11..8 of the axis write
// - all general outputs are low after reset
// - status mode: output 7 high while driving and decelerating
// - status mode: output 6 high while driving and accelerating
// - status mode: output 5 high below lower compare, low above it
// - status mode: output 4 high above upper compare, low below it
// - each axis has four more general outputs 3..0
// - outputs 3..0 of all axes come from one common 16-bit write
// - all logic runs on CLK_SYS; encoder and in-position pins pass two-flop synchronisers
`default_nettype none
module axis_pulse_and_status_outputs
   import axis_pins_pkg::*;
(
   input  wire logic                                     CLK_SYS,
   input  wire logic                                     NRST,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       AXIS_SELECT,
   input  wire logic                                     AXIS_OUT_WR,
   input  wire logic [axis_pins_pkg::HOST_DATA_W-1:0]    AXIS_OUT_DATA,
   input  wire logic                                     COMMON_OUT_WR,
   input  wire logic [axis_pins_pkg::HOST_DATA_W-1:0]    COMMON_OUT_DATA,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       DRIVE_START,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       DRIVE_STOP,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       DRIVE_MINUS,
   input  wire logic [axis_pins_pkg::HALF_PERIOD_W-1:0]  HALF_PERIOD,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       ACCELERATING,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       DECELERATING,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       HOME_SEARCH,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       INTERP_RUN,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       INPOS_ENABLE,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       INPOS_ACTIVE_HIGH,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       PULSE_DIR_MODE,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       UP_DOWN_MODE,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       CLEAR_SELECT,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       CLEAR_REQUEST,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       STATUS_MODE,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       COMPARE_REAL,
   input  wire logic [axis_pins_pkg::NUM_AXES*axis_pins_pkg::POS_W-1:0]
                                                         LOGICAL_POSITION,
   input  wire logic [axis_pins_pkg::NUM_AXES*axis_pins_pkg::POS_W-1:0]
                                                         COMPARE_PLUS,
   input  wire logic [axis_pins_pkg::NUM_AXES*axis_pins_pkg::POS_W-1:0]
                                                         COMPARE_MINUS,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       ENCODER_PHASE_A,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       ENCODER_PHASE_B,
   input  wire logic [axis_pins_pkg::NUM_AXES-1:0]       SERVO_IN_POSITION_IN,
   output var  logic [axis_pins_pkg::NUM_AXES-1:0]       MINUS_PULSE_OUT,
   output var  logic [axis_pins_pkg::NUM_AXES-1:0]       MOTION_ACTIVE_OUT,
   output var  logic [axis_pins_pkg::NUM_AXES-1:0]       PULSING,
   output var  logic [axis_pins_pkg::NUM_AXES*axis_pins_pkg::GPO_PER_AXIS-1:0]
                                                AXIS_GENERAL_OUTPUTS_HIGH,
   output var  logic [axis_pins_pkg::NUM_AXES*axis_pins_pkg::GPO_PER_AXIS-1:0]
                                                AXIS_GENERAL_OUTPUTS_LOW,
   output var  logic [axis_pins_pkg::NUM_AXES*axis_pins_pkg::POS_W-1:0]
                                                REAL_POSITION
);
   import axis_pins_pkg::*;

   localparam int GW = GPO_PER_AXIS;

   // pin synchronisers: stage two is read, and the encoder pins also read a third edge flop
   logic [NUM_AXES-1:0]      a_meta;
   logic [NUM_AXES-1:0]      a_sync;
   logic [NUM_AXES-1:0]      a_prev;
   logic [NUM_AXES-1:0]      b_meta;
   logic [NUM_AXES-1:0]      b_sync;
   logic [NUM_AXES-1:0]      b_prev;
   logic [NUM_AXES-1:0]      inpos_meta;
   logic [NUM_AXES-1:0]      inpos_sync;

   pulse_e                   pulse_state      [NUM_AXES];
   pulse_e                   next_pulse_state [NUM_AXES];
   logic [HALF_PERIOD_W-1:0] pulse_count      [NUM_AXES];
   logic [HALF_PERIOD_W-1:0] next_pulse_count [NUM_AXES];
   logic [NUM_AXES-1:0]      stop_pending;
   logic [NUM_AXES-1:0]      next_stop_pending;
   logic [NUM_AXES-1:0]      inpos_wait;
   logic [NUM_AXES-1:0]      next_inpos_wait;
   logic [NUM_AXES-1:0]      next_minus_pulse;
   logic [NUM_AXES-1:0]      next_motion_active;
   logic [NUM_AXES-1:0]      next_pulsing;

   logic [POS_W-1:0]         real_pos      [NUM_AXES];
   logic [POS_W-1:0]         next_real_pos [NUM_AXES];
   logic [NUM_AXES-1:0]      cmp_minus;
   logic [NUM_AXES-1:0]      next_cmp_minus;
   logic [NUM_AXES-1:0]      cmp_plus;
   logic [NUM_AXES-1:0]      next_cmp_plus;

   logic [GW-1:0]            gpo_high      [NUM_AXES];
   logic [GW-1:0]            next_gpo_high [NUM_AXES];
   logic [HOST_DATA_W-1:0]   gpo_low;
   logic [HOST_DATA_W-1:0]   next_gpo_low;
   logic [NUM_AXES*GW-1:0]   next_out_high;
   logic [NUM_AXES*POS_W-1:0] next_real_flat;

   always_comb
   begin
      logic                 running;
      logic                 step;
      logic                 up;
      logic                 down;
      logic                 inpos_ok;
      logic                 ends;
      logic signed [POS_W-1:0] pos;
      logic signed [POS_W-1:0] lim_p;
      logic signed [POS_W-1:0] lim_m;
      logic [GW-1:0]        status;
      running = 1'b0;
      step = 1'b0;
      up = 1'b0;
      down = 1'b0;
      inpos_ok = 1'b0;
      ends = 1'b0;
      pos = '0;
      lim_p = '0;
      lim_m = '0;
      status = '0;
      next_gpo_low = COMMON_OUT_WR ? COMMON_OUT_DATA : gpo_low;
      next_out_high = '0;
      next_real_flat = '0;
      for (int i = 0; i < NUM_AXES; i++)
      begin
         // drive pulse generator: equal half periods, a stop request
         // finishes the current low half so no short pulse escapes
         next_pulse_state[i] = pulse_state[i];
         next_pulse_count[i] = pulse_count[i];
         next_stop_pending[i] = stop_pending[i];
         ends = 1'b0;
         case (pulse_state[i])
            PULSE_IDLE:
            begin
               next_stop_pending[i] = 1'b0;
               next_pulse_count[i] = HP_ONE;
               if (DRIVE_START[i])
               begin
                  next_pulse_state[i] = PULSE_HIGH;
               end
            end
            PULSE_HIGH:
            begin
               if (DRIVE_STOP[i])
               begin
                  next_stop_pending[i] = 1'b1;
               end
               if (pulse_count[i] >= HALF_PERIOD)
               begin
                  next_pulse_count[i] = HP_ONE;
                  next_pulse_state[i] = PULSE_LOW;
               end
               else
               begin
                  next_pulse_count[i] = pulse_count[i] + HP_ONE;
               end
            end
            PULSE_LOW:
            begin
               if (DRIVE_STOP[i])
               begin
                  next_stop_pending[i] = 1'b1;
               end
               if (pulse_count[i] >= HALF_PERIOD)
               begin
                  next_pulse_count[i] = HP_ONE;
                  if (stop_pending[i] || DRIVE_STOP[i])
                  begin
                     next_pulse_state[i] = PULSE_IDLE;
                     ends = 1'b1;
                  end
                  else
                  begin
                     next_pulse_state[i] = PULSE_HIGH;
                  end
               end
               else
               begin
                  next_pulse_count[i] = pulse_count[i] + HP_ONE;
               end
            end
            default:
            begin
               next_pulse_state[i] = PULSE_IDLE;
            end
         endcase
         running = (next_pulse_state[i] != PULSE_IDLE);
         next_pulsing[i] = running;
         if (PULSE_DIR_MODE[i])
         begin
            next_minus_pulse[i] = DRIVE_MINUS[i];
         end
         else
         begin
            next_minus_pulse[i] = DRIVE_MINUS[i] &&
                                  (next_pulse_state[i] == PULSE_HIGH);
         end

         // in-position wait: set as pulses end, cleared on arrival
         inpos_ok = (inpos_sync[i] == INPOS_ACTIVE_HIGH[i]);
         next_inpos_wait[i] = inpos_wait[i];
         if (!INPOS_ENABLE[i] || inpos_ok)
         begin
            next_inpos_wait[i] = 1'b0;
         end
         else if (ends)
         begin
            next_inpos_wait[i] = 1'b1;
         end
         if (CLEAR_SELECT[i])
         begin
            next_motion_active[i] = CLEAR_REQUEST[i];
         end
         else
         begin
            next_motion_active[i] = running
                                 || HOME_SEARCH[i]
                                 || INTERP_RUN[i]
                                 || next_inpos_wait[i];
         end

         // real position counter from the encoder pins
         step = (a_sync[i] ^ a_prev[i]) ^ (b_sync[i] ^ b_prev[i]);
         if (UP_DOWN_MODE[i])
         begin
            up = a_sync[i] && !a_prev[i];
            down = b_sync[i] && !b_prev[i];
         end
         else
         begin
            up = step && (a_sync[i] ^ b_prev[i]);
            down = step && !(a_sync[i] ^ b_prev[i]);
         end
         // simultaneous up and down edges cancel out
         if (up && !down)
         begin
            next_real_pos[i] = real_pos[i] + POS_ONE;
         end
         else if (down && !up)
         begin
            next_real_pos[i] = real_pos[i] - POS_ONE;
         end
         else
         begin
            next_real_pos[i] = real_pos[i];
         end
         next_real_flat[i*POS_W +: POS_W] = next_real_pos[i];

         // compare status, held on equality
         pos = COMPARE_REAL[i] ? signed'(real_pos[i])
                               : signed'(LOGICAL_POSITION[i*POS_W +: POS_W]);
         lim_p = signed'(COMPARE_PLUS[i*POS_W +: POS_W]);
         lim_m = signed'(COMPARE_MINUS[i*POS_W +: POS_W]);
         next_cmp_minus[i] = cmp_minus[i];
         next_cmp_plus[i] = cmp_plus[i];
         if (pos < lim_m)
         begin
            next_cmp_minus[i] = 1'b1;
         end
         else if (pos > lim_m)
         begin
            next_cmp_minus[i] = 1'b0;
         end
         if (pos > lim_p)
         begin
            next_cmp_plus[i] = 1'b1;
         end
         else if (pos < lim_p)
         begin
            next_cmp_plus[i] = 1'b0;
         end

         // upper general outputs and their status alternate
         next_gpo_high[i] = gpo_high[i];
         if (AXIS_OUT_WR && AXIS_SELECT[i])
         begin
            next_gpo_high[i] = AXIS_OUT_DATA[AXIS_OUT_LSB +: GW];
         end
         status[STAT_DECEL_BIT] = running && DECELERATING[i];
         status[STAT_ACCEL_BIT] = running && ACCELERATING[i];
         status[STAT_BELOW_LOWER_COMPARE_OUT_BIT] = next_cmp_minus[i];
         status[STAT_ABOVE_UPPER_COMPARE_OUT_BIT] = next_cmp_plus[i];
         next_out_high[i*GW +: GW] = STATUS_MODE[i] ? status
                                                    : next_gpo_high[i];
      end
   end

   // CLK_SYS is the halved system clock; every flop runs on it
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         a_meta <= '0;
         a_sync <= '0;
         a_prev <= '0;
         b_meta <= '0;
         b_sync <= '0;
         b_prev <= '0;
         inpos_meta <= '0;
         inpos_sync <= '0;
         stop_pending <= '0;
         inpos_wait <= '0;
         cmp_minus <= '0;
         cmp_plus <= '0;
         gpo_low <= '0;
         MINUS_PULSE_OUT <= '0;
         MOTION_ACTIVE_OUT <= '0;
         PULSING <= '0;
         AXIS_GENERAL_OUTPUTS_HIGH <= '0;
         AXIS_GENERAL_OUTPUTS_LOW <= '0;
         REAL_POSITION <= '0;
         for (int i = 0; i < NUM_AXES; i++)
         begin
            pulse_state[i] <= PULSE_IDLE;
            pulse_count[i] <= HP_RESET;
            real_pos[i] <= POS_RESET;
            gpo_high[i] <= GPO_RESET;
         end
      end
      else
      begin
         a_meta <= ENCODER_PHASE_A;
         a_sync <= a_meta;
         a_prev <= a_sync;
         b_meta <= ENCODER_PHASE_B;
         b_sync <= b_meta;
         b_prev <= b_sync;
         inpos_meta <= SERVO_IN_POSITION_IN;
         inpos_sync <= inpos_meta;
         stop_pending <= next_stop_pending;
         inpos_wait <= next_inpos_wait;
         cmp_minus <= next_cmp_minus;
         cmp_plus <= next_cmp_plus;
         gpo_low <= next_gpo_low;
         MINUS_PULSE_OUT <= next_minus_pulse;
         MOTION_ACTIVE_OUT <= next_motion_active;
         PULSING <= next_pulsing;
         AXIS_GENERAL_OUTPUTS_HIGH <= next_out_high;
         AXIS_GENERAL_OUTPUTS_LOW <= next_gpo_low;
         REAL_POSITION <= next_real_flat;
         for (int i = 0; i < NUM_AXES; i++)
         begin
            pulse_state[i] <= next_pulse_state[i];
            pulse_count[i] <= next_pulse_count[i];
            real_pos[i] <= next_real_pos[i];
            gpo_high[i] <= next_gpo_high[i];
         end
      end
   end
endmodule // axis_pulse_and_status_outputs
`default_nettype wire

/* File: motor_encoder_model.sv */
// encoder and servo in-position model for axis 0 of the pin block
// assumes the bench calls its tasks just after a rising clock edge
`default_nettype none
module motor_encoder_model
(
   input  wire logic clk,
   input  wire logic up_down,
   output var  logic phase_a,
   output var  logic phase_b,
   output var  logic in_position
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      phase_a = 1'b0;
      phase_b = 1'b0;
      in_position = 1'b0;
   end
   // six cycles per level covers the sync chain plus edge flop
   task automatic hold_level();
      repeat (6) @(posedge clk);
      #2;
   endtask
   // the bench reaches the in-position pin only through this task
   task automatic settle(input logic lvl);
      in_position = lvl;
   endtask
   task automatic step(input logic up);
      if (up_down)
      begin
         phase_a = up;
         phase_b = !up;
         hold_level();
         phase_a = 1'b0;
         phase_b = 1'b0;
      end
      else if ((phase_a == phase_b) == up)
         phase_a = !phase_a;
      else
         phase_b = !phase_b;
      hold_level();
   endtask
endmodule // motor_encoder_model
`default_nettype wire

/* File: axis_pulse_and_status_outputs_props.sv */
// timing checks on axis 0 of the pin block
// assumes the block's ports and a single clock domain
`default_nettype none
module axis_outputs_checker
(
   input wire logic        CLK_SYS,
   input wire logic        NRST,
   input wire logic [3:0]  AXIS_SELECT,
   input wire logic        AXIS_OUT_WR,
   input wire logic [15:0] AXIS_OUT_DATA,
   input wire logic        COMMON_OUT_WR,
   input wire logic [15:0] COMMON_OUT_DATA,
   input wire logic [3:0]  DRIVE_MINUS,
   input wire logic [15:0] HALF_PERIOD,
   input wire logic [3:0]  ACCELERATING,
   input wire logic [3:0]  HOME_SEARCH,
   input wire logic [3:0]  INTERP_RUN,
   input wire logic [3:0]  INPOS_ENABLE,
   input wire logic [3:0]  INPOS_ACTIVE_HIGH,
   input wire logic [3:0]  PULSE_DIR_MODE,
   input wire logic [3:0]  CLEAR_SELECT,
   input wire logic [3:0]  CLEAR_REQUEST,
   input wire logic [3:0]  STATUS_MODE,
   input wire logic [3:0]  SERVO_IN_POSITION_IN,
   input wire logic [3:0]  MINUS_PULSE_OUT,
   input wire logic [3:0]  MOTION_ACTIVE_OUT,
   input wire logic [3:0]  PULSING,
   input wire logic [15:0] AXIS_GENERAL_OUTPUTS_HIGH,
   input wire logic [15:0] AXIS_GENERAL_OUTPUTS_LOW
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   a_reset_low: assert property ($rose(NRST) |->
      AXIS_GENERAL_OUTPUTS_HIGH == 16'h0000 &&
      AXIS_GENERAL_OUTPUTS_LOW == 16'h0000) else $error("outputs not low");
   a_axis_write: assert property (
      AXIS_OUT_WR && AXIS_SELECT[0] && !STATUS_MODE[0] |=>
      AXIS_GENERAL_OUTPUTS_HIGH[3:0] == $past(AXIS_OUT_DATA[11:8]))
      else $error("axis output write lost");
   a_common_write: assert property (COMMON_OUT_WR |=>
      AXIS_GENERAL_OUTPUTS_LOW == $past(COMMON_OUT_DATA))
      else $error("common output write lost");
   a_pulse_duty: assert property ($rose(MINUS_PULSE_OUT[0]) &&
      !PULSE_DIR_MODE[0] && DRIVE_MINUS[0] && HALF_PERIOD == 16'h0002 |->
      MINUS_PULSE_OUT[0] [*2] ##1 !MINUS_PULSE_OUT[0] [*2])
      else $error("pulse halves unequal");
   a_active_pulsing: assert property (PULSING[0] &&
      !CLEAR_SELECT[0] && !$past(CLEAR_SELECT[0]) |-> MOTION_ACTIVE_OUT[0])
      else $error("motion low while pulsing");
   a_active_home: assert property (
      (HOME_SEARCH[0] || INTERP_RUN[0]) && !CLEAR_SELECT[0] |=>
      MOTION_ACTIVE_OUT[0]) else $error("motion low during search");
   a_clear_mirror: assert property (CLEAR_SELECT[0] |=>
      MOTION_ACTIVE_OUT[0] == $past(CLEAR_REQUEST[0]))
      else $error("clear level not shown");
   a_inpos_hold: assert property ($fell(PULSING[0]) &&
      INPOS_ENABLE[0] && !CLEAR_SELECT[0] &&
      SERVO_IN_POSITION_IN[0] != INPOS_ACTIVE_HIGH[0] |->
      MOTION_ACTIVE_OUT[0] [*3]) else $error("motion fell before settle");
   a_status_accel: assert property (
      STATUS_MODE[0] && $past(STATUS_MODE[0]) |->
      AXIS_GENERAL_OUTPUTS_HIGH[2] == (PULSING[0] && $past(ACCELERATING[0])))
      else $error("accel status wrong");
endmodule // axis_outputs_checker
bind axis_pulse_and_status_outputs axis_outputs_checker chk (.*);
`default_nettype wire

/* File: axis_pulse_and_status_outputs_bench.sv */
// self-checking bench for the per-axis pin block, axis 0 in depth
// assumes the encoder model and the bound checker are compiled before
`default_nettype none
module axis_pulse_and_status_outputs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK_SYS, NRST, AXIS_OUT_WR, COMMON_OUT_WR, pa, pb, ip;
   logic [3:0] AXIS_SELECT, DRIVE_START, DRIVE_STOP, DRIVE_MINUS,
      ACCELERATING, DECELERATING, HOME_SEARCH, INTERP_RUN, INPOS_ENABLE,
      INPOS_ACTIVE_HIGH, PULSE_DIR_MODE, UP_DOWN_MODE, CLEAR_SELECT,
      CLEAR_REQUEST, STATUS_MODE, COMPARE_REAL, ENCODER_PHASE_A,
      ENCODER_PHASE_B, SERVO_IN_POSITION_IN, MINUS_PULSE_OUT,
      MOTION_ACTIVE_OUT, PULSING;
   logic [15:0] AXIS_OUT_DATA, COMMON_OUT_DATA, HALF_PERIOD,
      AXIS_GENERAL_OUTPUTS_HIGH, AXIS_GENERAL_OUTPUTS_LOW;
   logic [127:0] LOGICAL_POSITION, COMPARE_PLUS, COMPARE_MINUS,
      REAL_POSITION;
   int error_cnt, checks_done, hi, i;
   int pos[8] = '{10, 5, 3, 5, 20, 25, 20, -1};
   int exp_st[8] = '{3, 3, 2, 2, 3, 1, 1, 2};
   // other axes keep idle pins; axis 0 carries all encoder traffic
   assign ENCODER_PHASE_A = {3'h0, pa};
   assign ENCODER_PHASE_B = {3'h0, pb};
   assign SERVO_IN_POSITION_IN = {3'h0, ip};
   axis_pulse_and_status_outputs dut (.*);
   motor_encoder_model enc (.clk(CLK_SYS), .up_down(UP_DOWN_MODE[0]),
      .phase_a(pa), .phase_b(pb), .in_position(ip));
   always #25 CLK_SYS = ~CLK_SYS;
   task automatic tick();
      @(posedge CLK_SYS);
      #2;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // k=0 waits for the pulse train to end, k=1 for motion-active low
   task automatic wait_fall(input int k);
      int n;
      for (n = 0; n < 40 && (k ? MOTION_ACTIVE_OUT[0] : PULSING[0]) !== 0;
           n++)
         tick();
      chk("fall", 0, k ? MOTION_ACTIVE_OUT[0] : PULSING[0]);
      if (n == 40)
         stop_test();
   endtask
   task automatic host_wr(input logic common, input logic [3:0] sel,
                          input logic [15:0] d);
      AXIS_SELECT = sel;
      AXIS_OUT_DATA = d;
      COMMON_OUT_DATA = d;
      AXIS_OUT_WR = !common;
      COMMON_OUT_WR = common;
      tick();
      AXIS_OUT_WR = 1'b0;
      COMMON_OUT_WR = 1'b0;
      tick();
   endtask
   task automatic train(input logic stop_now);
      DRIVE_START = 4'h1;
      tick();
      DRIVE_START = 4'h0;
      DRIVE_STOP = {3'h0, stop_now};
      tick();
      DRIVE_STOP = 4'h0;
   endtask
   initial
   begin
      {CLK_SYS, NRST, AXIS_OUT_WR, COMMON_OUT_WR, AXIS_SELECT, DRIVE_START,
       DRIVE_STOP, DRIVE_MINUS, ACCELERATING, DECELERATING, HOME_SEARCH,
       INTERP_RUN, INPOS_ENABLE, INPOS_ACTIVE_HIGH, PULSE_DIR_MODE,
       UP_DOWN_MODE, CLEAR_SELECT, CLEAR_REQUEST, STATUS_MODE, COMPARE_REAL,
       AXIS_OUT_DATA, COMMON_OUT_DATA, LOGICAL_POSITION, COMPARE_PLUS,
       COMPARE_MINUS, error_cnt, checks_done} = '0;
      HALF_PERIOD = 16'h0002;
      repeat (10) @(posedge CLK_SYS);
      #2;
      NRST = 1'b1;
      chk("gpo_high", 0, AXIS_GENERAL_OUTPUTS_HIGH);
      chk("gpo_low", 0, AXIS_GENERAL_OUTPUTS_LOW);
      host_wr(1'b1, 4'h0, 16'hA5C3);
      chk("gpo_low", 16'hA5C3, AXIS_GENERAL_OUTPUTS_LOW);
      host_wr(1'b0, 4'h5, 16'hFB00);
      chk("gpo_high", 16'h0B0B, AXIS_GENERAL_OUTPUTS_HIGH);
      host_wr(1'b0, 4'h2, 16'h0600);
      chk("gpo_high", 16'h0B6B, AXIS_GENERAL_OUTPUTS_HIGH);
      HOME_SEARCH = 4'h1;
      repeat (2) tick();
      chk("active", 1, MOTION_ACTIVE_OUT[0]);
      CLEAR_SELECT = 4'h1;
      for (i = 1; i >= 0; i--)
      begin
         CLEAR_REQUEST = i[3:0];
         repeat (2) tick();
         chk("clear", i, MOTION_ACTIVE_OUT[0]);
      end
      {CLEAR_SELECT, HOME_SEARCH, INTERP_RUN} = {4'h0, 4'h0, 4'h1};
      repeat (2) tick();
      chk("active", 1, MOTION_ACTIVE_OUT[0]);
      INTERP_RUN = 4'h0;
      wait_fall(1);
      DRIVE_MINUS = 4'h1;
      STATUS_MODE = 4'h1;
      train(1'b0);
      ACCELERATING = 4'h1;
      hi = 0;
      repeat (20)
      begin
         hi += MINUS_PULSE_OUT[0];
         tick();
      end
      chk("high_half", 10, hi);
      chk("active", 1, MOTION_ACTIVE_OUT[0]);
      chk("status", 4'h4, AXIS_GENERAL_OUTPUTS_HIGH[3:0]);
      {ACCELERATING, DECELERATING} = {4'h0, 4'h1};
      repeat (2) tick();
      chk("status", 4'h8, AXIS_GENERAL_OUTPUTS_HIGH[3:0]);
      DRIVE_STOP = 4'h1;
      tick();
      DRIVE_STOP = 4'h0;
      wait_fall(0);
      wait_fall(1);
      chk("status", 0, AXIS_GENERAL_OUTPUTS_HIGH[3:0]);
      DECELERATING = 4'h0;
      PULSE_DIR_MODE = 4'h1;
      for (i = 0; i < 2; i++)
      begin
         DRIVE_MINUS = i[3:0];
         repeat (2) tick();
         chk("direction", i, MINUS_PULSE_OUT[0]);
      end
      PULSE_DIR_MODE = 4'h0;
      {INPOS_ENABLE, INPOS_ACTIVE_HIGH} = 8'h11;
      train(1'b1);
      wait_fall(0);
      repeat (5) tick();
      chk("active", 1, MOTION_ACTIVE_OUT[0]);
      enc.settle(1'b1);
      wait_fall(1);
      INPOS_ENABLE = 4'h0;
      repeat (4) enc.step(1'b1);
      repeat (8) enc.step(1'b0);
      chk("real", 32'hFFFFFFFC, REAL_POSITION[31:0]);
      UP_DOWN_MODE = 4'h1;
      repeat (3) enc.step(1'b1);
      chk("real", 32'hFFFFFFFF, REAL_POSITION[31:0]);
      enc.step(1'b0);
      chk("real", 32'hFFFFFFFE, REAL_POSITION[31:0]);
      COMPARE_PLUS[31:0] = 32'h00000005;
      COMPARE_MINUS[31:0] = 32'h00000014;
      for (i = 0; i < 8; i++)
      begin
         LOGICAL_POSITION[31:0] = pos[i];
         repeat (2) tick();
         chk("compare", exp_st[i],
             AXIS_GENERAL_OUTPUTS_HIGH[3:0]);
      end
      COMPARE_REAL = 4'h1;
      COMPARE_PLUS[31:0] = 32'hFFFFFFF0;
      COMPARE_MINUS[31:0] = 32'hFFFFFFF0;
      repeat (2) tick();
      chk("compare", 4'h1, AXIS_GENERAL_OUTPUTS_HIGH[3:0]);
      STATUS_MODE = 4'h0;
      repeat (2) tick();
      chk("gpo_high", 16'h0B6B, AXIS_GENERAL_OUTPUTS_HIGH);
      // mid-run reset with written outputs still standing
      NRST = 1'b0;
      tick();
      chk("gpo_high", 0, AXIS_GENERAL_OUTPUTS_HIGH);
      chk("gpo_low", 0, AXIS_GENERAL_OUTPUTS_LOW);
      NRST = 1'b1;
      tick();
      chk("active", 0, MOTION_ACTIVE_OUT[0]);
      stop_test();
   end
endmodule // axis_pulse_and_status_outputs_bench
`default_nettype wire
